/* serdes_cfg_defines.vh */
// Register map, field positions, reset values and codes for the config bank
`ifndef SERDES_CFG_DEFINES_VH
`define SERDES_CFG_DEFINES_VH

// Register addresses on the management register port
`define ADDR_FAST_TAPS 5'h05
`define ADDR_SLOW_LANE_PLL 5'h06
`define ADDR_LANE_CTRL_A 5'h07
`define ADDR_LANE_CTRL_B 5'h08
`define ADDR_LANE_ERR_VIEW 5'h10
`define ADDR_LANE_LOS_VIEW 5'h11
`define ADDR_LANE_STAT_VIEW 5'h12

// Reset values
`define RST_FAST_TAPS 16'h2000
`define RST_SLOW_LANE_PLL 16'h8115
`define RST_LANE_CTRL_A 16'hDD05
`define RST_LANE_CTRL_B 16'h000D
`define RST_SLOW_FACTOR_X2 8'h14

// Fast side register fields
`define FAST_RX_FLIP_BIT 15
`define FAST_TX_FLIP_BIT 14
`define FAST_RSVD_BIT 13
`define POST1_MSB 12
`define POST1_LSB 8
`define PRE_MSB 7
`define PRE_LSB 4
`define POST2_MSB 3
`define POST2_LSB 0

// Slow side register fields
`define BCAST_BIT 15
`define LANE_SEL_MSB 14
`define LANE_SEL_LSB 12
`define LOOP_BW_MSB 9
`define LOOP_BW_LSB 8
`define PLL_EN_BIT 4
`define MULT_MSB 3
`define MULT_LSB 0

// Codes
`define POST1_ZERO_MAG 4'hC
`define LOOP_BW_NO_JC 2'h1
`define LOOP_BW_WITH_JC 2'h2
`define LANE_COUNT 8

`endif

/* tap_weight_decode.v */
// Sign-magnitude transmit tap code to signed count of 2.5 percent steps
`timescale 1ns/1ps
`default_nettype none
module tap_weight_decode #(
  parameter integer W = 4,
  parameter HAS_HOLE = 1'b0,
  parameter [3:0] HOLE_MAG = 4'h0
) (
  // Tap code
  input wire [W-1:0] code,
  // Signed weight in 2.5 percent steps
  output reg signed [5:0] steps
);
  reg [3:0] mag;
  always @* begin
    mag = 4'h0;
    mag[W-2:0] = code[W-2:0];
    if (HAS_HOLE && (mag == HOLE_MAG)) begin
      // This magnitude is a zero weight, not the next step up
      mag = 4'h0;
    end
    if (code[W-1]) begin
      steps = -$signed({2'b00, mag});
    end else begin
      steps = $signed({2'b00, mag});
    end
  end
endmodule
`default_nettype wire

/* pll_mult_decode.v */
// Slow side PLL multiplier code to factor in half units
`timescale 1ns/1ps
`default_nettype none
module pll_mult_decode (
  // Multiplier code
  input wire [3:0] code,
  // Factor times two, and reserved flag
  output reg [7:0] factor_x2,
  output reg reserved
);
  always @* begin
    reserved = 1'b0;
    case (code)
      4'h0: factor_x2 = 8'h08;
      4'h1: factor_x2 = 8'h0A;
      4'h2: factor_x2 = 8'h0C;
      4'h4: factor_x2 = 8'h10;
      4'h5: factor_x2 = 8'h14;
      4'h6: factor_x2 = 8'h18;
      4'h7: factor_x2 = 8'h19;
      4'h8: factor_x2 = 8'h1E;
      4'h9: factor_x2 = 8'h28;
      4'hA: factor_x2 = 8'h32;
      4'hD: factor_x2 = 8'h64;
      4'hE: factor_x2 = 8'h82;
      default: begin
        factor_x2 = 8'h00;
        reserved = 1'b1;
      end
    endcase
  end
endmodule
`default_nettype wire

/* serdes_tap_and_lane_config_regs.v */
// Fast side polarity and tap register, slow side lane and PLL register
//
// Behaviour
// - Bit 15 flips fast receive pair polarity.
// - Bit 14 flips fast transmit pair polarity.
// - Bit 13 reserved read/write, resets to one.
// - Bits 12:8 post-cursor-one weight, reset zero.
// - Post-cursor-one sign-magnitude; code 12 means zero.
// - Bits 3:0 post-cursor-two sign-magnitude weight.
// - Bits 7:4 pre-cursor sign-magnitude weight.
// - Broadcast bit set: lane writes reach all lanes.
// - Broadcast clear: lane writes reach selected lane.
// - Bits 14:12 select lane, reset lane zero.
// - Lane select picks mirrored lane status always.
// - Loop bandwidth code 01 default, 10 external.
// - PLL enable bit, forced off by power-down.
// - Bits 3:0 multiplier code, reset 0101.
// - Reserved bits read/write, reset zero.
// - Multiplier codes map to listed factors.
`timescale 1ns/1ps
`default_nettype none
`include "serdes_cfg_defines.vh"
module serdes_tap_and_lane_config_regs (
  // Clock and reset
  input wire clk_sys,
  input wire rst_b,
  // Management register port
  input wire [4:0] reg_addr,
  input wire reg_wr,
  input wire [15:0] reg_wdata,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  output reg reg_rd_valid,
  // Power-down controls
  input wire channel_power_down_n,
  input wire global_power_down,
  // Per-lane status from the lanes, lane n in bits 16n+15:16n
  input wire [127:0] lane_error_count,
  input wire [127:0] lane_signal_loss_count,
  input wire [127:0] lane_status_view,
  // Fast side controls
  output reg fast_rx_polarity_flip,
  output reg fast_tx_polarity_flip,
  output reg [4:0] tx_postcursor_one_weight,
  output reg [3:0] tx_precursor_weight,
  output reg [3:0] tx_postcursor_two_weight,
  output reg signed [5:0] postcursor_one_steps,
  output reg signed [5:0] precursor_steps,
  output reg signed [5:0] postcursor_two_steps,
  // Slow side controls
  output reg broadcast_lane_write,
  output reg [2:0] lane_select,
  output reg [1:0] slow_pll_loop_bw,
  output reg slow_pll_loop_bw_reserved,
  output reg slow_pll_enable,
  output reg [3:0] slow_pll_multiplier,
  output reg [7:0] slow_pll_factor_x2,
  output reg slow_pll_multiplier_reserved,
  // Lane-specific register copies, lane n in bits 16n+15:16n
  output wire [127:0] lane_ctrl_a,
  output wire [127:0] lane_ctrl_b
);

  // Stored register images
  reg [15:0] fast_taps;
  reg [15:0] slow_lane_pll;
  reg [15:0] ctrl_a_mem [0:7];
  reg [15:0] ctrl_b_mem [0:7];

  // Mirrored status of the selected lane
  reg [15:0] err_view;
  reg [15:0] los_view;
  reg [15:0] stat_view;

  // Next-value and decode wires
  reg [7:0] lane_wr_mask;
  reg [15:0] next_rdata;
  wire wr_fast;
  wire wr_slow;
  wire wr_ctrl_a;
  wire wr_ctrl_b;
  wire [2:0] cur_sel;
  wire cur_bcast;
  wire signed [5:0] dec_post1;
  wire signed [5:0] dec_pre;
  wire signed [5:0] dec_post2;
  wire [7:0] dec_factor;
  wire dec_mult_rsvd;
  integer i;
  wire [1:0] cur_loop_bw;
  wire [3:0] cur_mult;
  wire cur_pll_en;
  wire pll_forced_off;
  wire bw_code_reserved;

  // Reset images; field outputs other than slow_pll_enable, which resets to zero, take their reset values
  // from these; decoded outputs reset to constants, so both agree with register read-back out of reset
  localparam [15:0] FAST_RST = `RST_FAST_TAPS;
  localparam [15:0] SLOW_RST = `RST_SLOW_LANE_PLL;

  // Lane mask from the broadcast bit and lane select: all ones, or one-hot on the selected lane
  function [7:0] lane_mask;
    input bcast;
    input [2:0] sel;
    begin
      if (bcast) begin
        lane_mask = 8'hFF;
      end else begin
        lane_mask = 8'h01 << sel;
      end
    end
  endfunction

  // Picks one 16-bit lane slice out of a 128-bit bundle
  function [15:0] lane_slice;
    input [127:0] bundle;
    input [2:0] sel;
    begin
      lane_slice = bundle[{sel, 4'h0} +: 16];
    end
  endfunction

  // Write strobe qualified by one register address
  function wr_hit;
    input wr;
    input [4:0] addr;
    input [4:0] target;
    begin
      wr_hit = wr && (addr == target);
    end
  endfunction

  // Loop bandwidth codes other than the two defined ones
  function bw_reserved;
    input [1:0] code;
    begin
      bw_reserved = (code != `LOOP_BW_NO_JC) && (code != `LOOP_BW_WITH_JC);
    end
  endfunction

  assign wr_fast = wr_hit(reg_wr, reg_addr, `ADDR_FAST_TAPS);
  assign wr_slow = wr_hit(reg_wr, reg_addr, `ADDR_SLOW_LANE_PLL);
  assign wr_ctrl_a = wr_hit(reg_wr, reg_addr, `ADDR_LANE_CTRL_A);
  assign wr_ctrl_b = wr_hit(reg_wr, reg_addr, `ADDR_LANE_CTRL_B);

  assign cur_sel = slow_lane_pll[`LANE_SEL_MSB:`LANE_SEL_LSB];
  assign cur_bcast = slow_lane_pll[`BCAST_BIT];
  assign cur_loop_bw = slow_lane_pll[`LOOP_BW_MSB:`LOOP_BW_LSB];
  assign cur_mult = slow_lane_pll[`MULT_MSB:`MULT_LSB];
  assign cur_pll_en = slow_lane_pll[`PLL_EN_BIT];
  assign bw_code_reserved = bw_reserved(cur_loop_bw);

  // Either power-down control shuts the PLL; the stored enable bit is
  // left alone so the PLL comes back by itself once power-down lifts
  assign pll_forced_off = !channel_power_down_n || global_power_down;

  // Lane-specific write steering
  // Mask comes from the stored select, never from the write data
  always @* begin
    lane_wr_mask = lane_mask(cur_bcast, cur_sel);
  end

  // Fast side register, all sixteen bits read/write
  // Bit 13 is stored like the rest; software is expected to keep it set
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      fast_taps <= `RST_FAST_TAPS;
    end else if (wr_fast) begin
      fast_taps <= reg_wdata;
    end
  end

  // Slow side register; reserved bits are kept as written
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      slow_lane_pll <= `RST_SLOW_LANE_PLL;
    end else if (wr_slow) begin
      slow_lane_pll <= reg_wdata;
    end
  end

  // Per-lane copies; a lane changes only when its mask bit is set
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      // Every lane copy starts from the same reset image
      for (i = 0; i < `LANE_COUNT; i = i + 1) begin
        ctrl_a_mem[i] <= `RST_LANE_CTRL_A;
        ctrl_b_mem[i] <= `RST_LANE_CTRL_B;
      end
    end else begin
      // Idle lanes keep their settings through a write aimed elsewhere
      for (i = 0; i < `LANE_COUNT; i = i + 1) begin
        if (wr_ctrl_a && lane_wr_mask[i]) begin
          ctrl_a_mem[i] <= reg_wdata;
        end
        if (wr_ctrl_b && lane_wr_mask[i]) begin
          ctrl_b_mem[i] <= reg_wdata;
        end
      end
    end
  end

  // Lane copies leave straight from their flip-flops
  genvar g;
  generate
    for (g = 0; g < `LANE_COUNT; g = g + 1) begin : lane_out
      assign lane_ctrl_a[16*g +: 16] = ctrl_a_mem[g];
      assign lane_ctrl_b[16*g +: 16] = ctrl_b_mem[g];
    end
  endgenerate

  // Status mirror follows lane select whatever the broadcast bit says.
  // Registered so a status read never sees a half-switched lane.
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      err_view <= 16'h0000;
      los_view <= 16'h0000;
      stat_view <= 16'h0000;
    end else begin
      err_view <= lane_slice(lane_error_count, cur_sel);
      los_view <= lane_slice(lane_signal_loss_count, cur_sel);
      stat_view <= lane_slice(lane_status_view, cur_sel);
    end
  end

  // Tap decoders
  // Combinational decode; the registered outputs below absorb its delay
  tap_weight_decode #(
    .W(5),
    .HAS_HOLE(1'b1),
    .HOLE_MAG(`POST1_ZERO_MAG)
  ) u_post1 (
    .code(fast_taps[`POST1_MSB:`POST1_LSB]),
    .steps(dec_post1)
  );

  tap_weight_decode #(
    .W(4),
    .HAS_HOLE(1'b0),
    .HOLE_MAG(4'h0)
  ) u_pre (
    .code(fast_taps[`PRE_MSB:`PRE_LSB]),
    .steps(dec_pre)
  );

  tap_weight_decode #(
    .W(4),
    .HAS_HOLE(1'b0),
    .HOLE_MAG(4'h0)
  ) u_post2 (
    .code(fast_taps[`POST2_MSB:`POST2_LSB]),
    .steps(dec_post2)
  );

  pll_mult_decode u_mult (
    .code(slow_lane_pll[`MULT_MSB:`MULT_LSB]),
    .factor_x2(dec_factor),
    .reserved(dec_mult_rsvd)
  );

  // Fast side outputs, one cycle behind the register image
  // Codes leave as stored; the steps outputs carry their decoded weight
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      fast_rx_polarity_flip <= FAST_RST[`FAST_RX_FLIP_BIT];
      fast_tx_polarity_flip <= FAST_RST[`FAST_TX_FLIP_BIT];
      tx_postcursor_one_weight <= FAST_RST[`POST1_MSB:`POST1_LSB];
      tx_precursor_weight <= FAST_RST[`PRE_MSB:`PRE_LSB];
      tx_postcursor_two_weight <= FAST_RST[`POST2_MSB:`POST2_LSB];
      postcursor_one_steps <= 6'sh00;
      precursor_steps <= 6'sh00;
      postcursor_two_steps <= 6'sh00;
    end else begin
      fast_rx_polarity_flip <= fast_taps[`FAST_RX_FLIP_BIT];
      fast_tx_polarity_flip <= fast_taps[`FAST_TX_FLIP_BIT];
      tx_postcursor_one_weight <= fast_taps[`POST1_MSB:`POST1_LSB];
      tx_precursor_weight <= fast_taps[`PRE_MSB:`PRE_LSB];
      tx_postcursor_two_weight <= fast_taps[`POST2_MSB:`POST2_LSB];
      postcursor_one_steps <= dec_post1;
      precursor_steps <= dec_pre;
      postcursor_two_steps <= dec_post2;
    end
  end

  // Slow side outputs
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      broadcast_lane_write <= SLOW_RST[`BCAST_BIT];
      lane_select <= SLOW_RST[`LANE_SEL_MSB:`LANE_SEL_LSB];
      slow_pll_loop_bw <= SLOW_RST[`LOOP_BW_MSB:`LOOP_BW_LSB];
      slow_pll_loop_bw_reserved <= 1'b0;
      // Held off in reset; the PLL starts on the first edge after release unless power-down is asserted
      slow_pll_enable <= 1'b0;
      slow_pll_multiplier <= SLOW_RST[`MULT_MSB:`MULT_LSB];
      slow_pll_factor_x2 <= `RST_SLOW_FACTOR_X2;
      slow_pll_multiplier_reserved <= 1'b0;
    end else begin
      broadcast_lane_write <= cur_bcast;
      lane_select <= cur_sel;
      slow_pll_loop_bw <= cur_loop_bw;
      slow_pll_loop_bw_reserved <= bw_code_reserved;
      // Power-down overrides the stored enable without touching it
      slow_pll_enable <= cur_pll_en && !pll_forced_off;
      slow_pll_multiplier <= cur_mult;
      // Reserved multiplier codes are stored and flagged, never remapped
      slow_pll_factor_x2 <= dec_factor;
      slow_pll_multiplier_reserved <= dec_mult_rsvd;
    end
  end

  // Read mux; lane registers show the selected lane's copy
  // Unmapped addresses read as zero; nothing is flagged
  always @* begin
    case (reg_addr)
      `ADDR_FAST_TAPS: next_rdata = fast_taps;
      `ADDR_SLOW_LANE_PLL: next_rdata = slow_lane_pll;
      `ADDR_LANE_CTRL_A: next_rdata = ctrl_a_mem[cur_sel];
      `ADDR_LANE_CTRL_B: next_rdata = ctrl_b_mem[cur_sel];
      `ADDR_LANE_ERR_VIEW: next_rdata = err_view;
      `ADDR_LANE_LOS_VIEW: next_rdata = los_view;
      `ADDR_LANE_STAT_VIEW: next_rdata = stat_view;
      default: next_rdata = 16'h0000;
    endcase
  end

  // Read data held until the next read
  // A read in the cycle of a write to the same register returns the old
  // value, since the image only changes on that same edge
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 16'h0000;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

endmodule
`default_nettype wire

/* serdes_cfg_chk.sv */
// Port checker for the config register bank
`timescale 1ns/1ps
`default_nettype none
module serdes_cfg_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Register port
  input wire logic [4:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic reg_rd_valid,
  // Power-down and controls
  input wire logic channel_power_down_n,
  input wire logic global_power_down,
  input wire logic fast_rx_polarity_flip,
  input wire logic fast_tx_polarity_flip,
  input wire logic [4:0] tx_postcursor_one_weight,
  input wire logic broadcast_lane_write,
  input wire logic [2:0] lane_select,
  input wire logic slow_pll_enable
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // Image loads on the taking edge, outputs one edge later
  wire fast_wr = reg_wr && reg_addr == 5'h05;
  wire slow_wr = reg_wr && reg_addr == 5'h06;
  a_read_answered: assert property (
    reg_rd |=> reg_rd_valid) else $error("read not answered");
  a_no_stray_valid: assert property (
    !reg_rd |=> !reg_rd_valid) else $error("stray read valid");
  a_rx_flip_load: assert property (
    fast_wr |=> ##1 fast_rx_polarity_flip == $past(reg_wdata[15], 2))
    else $error("rx flip not loaded");
  a_tx_flip_load: assert property (
    fast_wr |=> ##1 fast_tx_polarity_flip == $past(reg_wdata[14], 2))
    else $error("tx flip not loaded");
  a_post1_field_load: assert property (
    fast_wr |=> ##1
    tx_postcursor_one_weight == $past(reg_wdata[12:8], 2))
    else $error("post1 field not loaded");
  a_lane_sel_load: assert property (
    slow_wr |=> ##1 lane_select == $past(reg_wdata[14:12], 2))
    else $error("lane select not loaded");
  a_bcast_load: assert property (
    slow_wr |=> ##1 broadcast_lane_write == $past(reg_wdata[15], 2))
    else $error("broadcast bit not loaded");
  a_pll_forced_off: assert property (
    (!channel_power_down_n || global_power_down) |=> !slow_pll_enable)
    else $error("pll not forced off");
endmodule
bind serdes_tap_and_lane_config_regs serdes_cfg_chk u_chk (
  .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
  .reg_rd_valid(reg_rd_valid),
  .channel_power_down_n(channel_power_down_n),
  .global_power_down(global_power_down),
  .fast_rx_polarity_flip(fast_rx_polarity_flip),
  .fast_tx_polarity_flip(fast_tx_polarity_flip),
  .tx_postcursor_one_weight(tx_postcursor_one_weight),
  .broadcast_lane_write(broadcast_lane_write),
  .lane_select(lane_select), .slow_pll_enable(slow_pll_enable));
`default_nettype wire

/* mgmt_host_model.sv */
// Management host model driving the register port
`timescale 1ns/1ps
`default_nettype none
module mgmt_host_model (
  // Clock
  input wire logic clk_sys,
  // Register port
  output logic [4:0] reg_addr,
  output logic reg_wr,
  output logic [15:0] reg_wdata,
  output logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rd_valid
);
  initial begin
    reg_addr = 5'h00;
    reg_wr = 1'b0;
    reg_wdata = 16'h0000;
    reg_rd = 1'b0;
  end
  // Callers pick the lane and clear broadcast before a one-lane write
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  // A missing valid pulse turns the data unknown so any compare fails
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    d = (reg_rd_valid === 1'b1) ? reg_rdata : 16'hXXXX;
  endtask
endmodule
`default_nettype wire

/* tb_top.sv */
// Self-checking bench for the config register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_sys, rst_b, pd_n, gpd;
  logic [127:0] err_in, los_in, stat_in;
  wire [4:0] addr, p1_w;
  wire wr, rd, rvalid, rxf, txf, bcast, bwr, pll_en, mres;
  wire [15:0] rdata, wd_bus;
  wire [5:0] p1_s, pre_s, p2_s;
  wire [2:0] lsel;
  wire [1:0] bw;
  wire [3:0] pre_w, p2_w, mult;
  wire [7:0] fac_x2;
  wire [127:0] lane_a, lane_b;
  logic [15:0] wd;
  logic [4:0] c;
  logic [7:0] fac [16] = '{8'h08, 8'h0A, 8'h0C, 8'h00, 8'h10, 8'h14,
    8'h18, 8'h19, 8'h1E, 8'h28, 8'h32, 8'h00, 8'h00, 8'h64, 8'h82, 8'h00};
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;
  serdes_tap_and_lane_config_regs u_serdes_tap_and_lane_config_regs (
    .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(addr), .reg_wr(wr),
    .reg_wdata(wd_bus), .reg_rd(rd), .reg_rdata(rdata),
    .reg_rd_valid(rvalid), .channel_power_down_n(pd_n),
    .global_power_down(gpd), .lane_error_count(err_in),
    .lane_signal_loss_count(los_in), .lane_status_view(stat_in),
    .fast_rx_polarity_flip(rxf), .fast_tx_polarity_flip(txf),
    .tx_postcursor_one_weight(p1_w), .tx_precursor_weight(pre_w),
    .tx_postcursor_two_weight(p2_w), .postcursor_one_steps(p1_s),
    .precursor_steps(pre_s), .postcursor_two_steps(p2_s),
    .broadcast_lane_write(bcast), .lane_select(lsel),
    .slow_pll_loop_bw(bw), .slow_pll_loop_bw_reserved(bwr),
    .slow_pll_enable(pll_en), .slow_pll_multiplier(mult),
    .slow_pll_factor_x2(fac_x2), .slow_pll_multiplier_reserved(mres),
    .lane_ctrl_a(lane_a), .lane_ctrl_b(lane_b));
  mgmt_host_model u_mgmt_host_model (
    .clk_sys(clk_sys), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wd_bus),
    .reg_rd(rd), .reg_rdata(rdata), .reg_rd_valid(rvalid));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic check(input string what, input logic [15:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic w(input logic [4:0] a, input logic [15:0] d);
    u_mgmt_host_model.wr(a, d);
    @(negedge clk_sys);
  endtask
  task automatic rc(input string what, input logic [4:0] a,
                    input logic [15:0] exp);
    logic [15:0] d;
    u_mgmt_host_model.rd(a, d);
    check(what, d, exp);
  endtask
  function automatic logic [15:0] tap(input logic s, input logic [3:0] m);
    return {10'h000, s ? 6'h00 - {2'b00, m} : {2'b00, m}};
  endfunction
  task tally_and_finish;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      tally_and_finish;
    end
  end
  initial begin
    rst_b = 1'b0;
    pd_n = 1'b1;
    gpd = 1'b0;
    for (int i = 0; i < 8; i++) begin
      err_in[16*i+:16] = 16'h1000 + 16'(i);
      los_in[16*i+:16] = 16'h2000 + 16'(i);
      stat_in[16*i+:16] = 16'h3000 + 16'(i);
    end
    repeat (10) @(negedge clk_sys);
    rst_b = 1'b1;
    rc("fast reset", 5'h05, 16'h2000);
    rc("slow reset", 5'h06, 16'h8115);
    check("factor reset", {8'h00, fac_x2}, 16'h0014);
    check("pll reset", {15'h0000, pll_en}, 16'h0001);
    for (int i = 0; i < 8; i++)
      check("lane a reset", lane_a[16*i+:16], 16'hDD05);
    $display("test reset done");
    for (int i = 0; i < 32; i++) begin
      c = 5'(i);
      wd = {c[0], c[1], c[2], c, c[3:0], ~c[3:0]};
      w(5'h05, wd);
      check("rx flip", {15'h0000, rxf}, {15'h0000, c[0]});
      check("tx flip", {15'h0000, txf}, {15'h0000, c[1]});
      check("post1 field", {11'h000, p1_w}, {11'h000, c});
      check("post1", {10'h000, p1_s},
            tap(c[4], c[3:0] == 4'hC ? 4'h0 : c[3:0]));
      check("pre", {10'h000, pre_s}, tap(c[3], {1'b0, c[2:0]}));
      check("post2", {10'h000, p2_s}, tap(~c[3], {1'b0, ~c[2:0]}));
      check("pre field", {12'h000, pre_w}, {12'h000, c[3:0]});
      check("post2 field", {12'h000, p2_w}, {12'h000, ~c[3:0]});
      rc("fast read", 5'h05, wd);
    end
    $display("test taps done");
    for (int i = 0; i < 16; i++) begin
      c = 5'(i);
      wd = {4'h8, 2'b00, c[1:0], 3'b000, 1'b1, c[3:0]};
      w(5'h06, wd);
      check("factor", {8'h00, fac_x2}, {8'h00, fac[i]});
      check("mult", {12'h000, mult}, {12'h000, c[3:0]});
      check("mult rsvd", {15'h0000, mres},
            {15'h0000, fac[i] == 8'h00});
      check("bw", {14'h0000, bw}, {14'h0000, c[1:0]});
      check("bw rsvd", {15'h0000, bwr},
            {15'h0000, c[1:0] == 2'h0 || c[1:0] == 2'h3});
      rc("slow read", 5'h06, wd);
    end
    w(5'h06, 16'h8CF5);
    rc("slow rsvd", 5'h06, 16'h8CF5);
    $display("test pll codes done");
    for (int j = 0; j < 4; j++) begin
      pd_n = j != 1;
      gpd = j == 2;
      w(5'h06, j == 3 ? 16'h8105 : 16'h8115);
      check("pll en", {15'h0000, pll_en}, {15'h0000, j == 0});
    end
    pd_n = 1'b1;
    w(5'h06, 16'h8115);
    w(5'h07, 16'h1234);
    for (int i = 0; i < 8; i++)
      check("bcast a", lane_a[16*i+:16], 16'h1234);
    w(5'h06, 16'h3115);
    check("bcast off", {15'h0000, bcast}, 16'h0000);
    w(5'h07, 16'hABCD);
    w(5'h08, 16'h5A5A);
    for (int i = 0; i < 8; i++) begin
      check("lane a", lane_a[16*i+:16], i == 3 ? 16'hABCD : 16'h1234);
      check("lane b", lane_b[16*i+:16], i == 3 ? 16'h5A5A : 16'h000D);
    end
    rc("lane3 a", 5'h07, 16'hABCD);
    rc("lane3 b", 5'h08, 16'h5A5A);
    w(5'h06, 16'h5115);
    check("lane sel", {13'h0000, lsel}, 16'h0005);
    rc("lane5 a", 5'h07, 16'h1234);
    rc("err view", 5'h10, 16'h1005);
    rc("los view", 5'h11, 16'h2005);
    rc("stat view", 5'h12, 16'h3005);
    w(5'h06, 16'hD115);
    check("bcast on", {15'h0000, bcast}, 16'h0001);
    stat_in[16*5+:16] = 16'h3ABC;
    repeat (2) @(negedge clk_sys);
    rc("stat bcast", 5'h12, 16'h3ABC);
    w(5'h10, 16'hFFFF);
    rc("view ro", 5'h10, 16'h1005);
    rc("unmapped", 5'h1F, 16'h0000);
    $display("test lanes done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
